// file: indoor_tx_ctl.sv
// indoor unit side: AHB-Lite registers drive the command link
// assumes: single AHB-Lite master, hold_state pin asynchronous
`timescale 1ns/1ns
module indoor_tx_ctl
  import tx_cmd_pkg::*;
#(
  parameter int PWD_LEN = 0
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // terminal hold state pin
  input  wire logic        hold_state,
  // command link
  tx_cmd_if.ctl            link
);
  if (PWD_LEN < 0 || PWD_LEN > 4) begin : g_bad_pwd
    $error("PWD_LEN must be 0 to 4");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic        hs1_r, hs2_r, hs3_r;
  logic        wp_r, wp_nxt;
  logic [7:0]  wa_r, wa_nxt;
  logic [31:0] rd_r, rd_nxt;
  ctl_state_t  st_r, st_nxt;
  logic [7:0]  op_r, op_nxt;
  logic [7:0]  adj_r, adj_nxt;
  logic        pinj_r, pinj_nxt;
  logic [31:0] pwd_r, pwd_nxt;
  logic [3:0]  ix_r, ix_nxt;
  logic [1:0]  rc_r, rc_nxt;
  logic [7:0]  r0_r, r0_nxt;
  logic [7:0]  r1_r, r1_nxt;
  logic        ref_r, ref_nxt;
  logic        auto_r, auto_nxt;
  logic [7:0]  cb_r, cb_nxt;
  logic        cp_r, cp_nxt;
  logic        cv_r, cv_nxt;
  logic        cl_r, cl_nxt;

  // hold pin: two stages, then an edge stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs1_r <= 1'b0;
      hs2_r <= 1'b0;
      hs3_r <= 1'b0;
    end else if (ce) begin
      hs1_r <= hold_state;
      hs2_r <= hs1_r;
      hs3_r <= hs2_r;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic        take;
  logic        pw;
  logic [3:0]  len;
  logic [7:0]  nb;
  logic [31:0] st_word;

  always_comb begin
    take = hsel && htrans[1] && hready;
    pw   = PWD_LEN > 0 && (op_r == `OP_PA_ON || op_r == `OP_TX_EN
        || op_r == `OP_PWR_STEP || op_r == `OP_MOD_OFF);
    len  = 4'h3 + (pw ? 4'(PWD_LEN) : 4'h0)
         + ((op_r == `OP_PWR_STEP) ? 4'h1 : 4'h0);
    case (ix_r)
      4'h0:    nb = `CMD_HDR0;
      4'h1:    nb = `CMD_HDR1;
      4'h2:    nb = op_r;
      default: nb = (pw && ix_r < 4'(3 + PWD_LEN))
                  ? pwd_r[8*2'(ix_r[1:0] + 2'h1) +: 8] : adj_r;
    endcase
    st_word = 32'h0;
    st_word[`ST_BUSY_BIT] = st_r != CTL_IDLE;
    st_word[`ST_HOLD_BIT] = hs2_r;
    st_word[`ST_REFUSE_BIT] = ref_r;
    st_word[`ST_CNT_LSB +: 2] = rc_r;
    st_word[`ST_RSP0_LSB +: 8] = r0_r;
    st_word[`ST_RSP1_LSB +: 8] = r1_r;

    wp_nxt = take && hwrite;
    wa_nxt = take ? haddr[7:0] : wa_r;
    rd_nxt = rd_r;
    if (take && !hwrite) begin
      case (haddr[7:0])
        `REG_CMD:    rd_nxt = {15'h0, pinj_r, adj_r, op_r};
        `REG_PWD:    rd_nxt = pwd_r;
        `REG_STATUS: rd_nxt = st_word;
        default:     rd_nxt = 32'h0;
      endcase
    end
    st_nxt   = st_r;
    op_nxt   = op_r;
    adj_nxt  = adj_r;
    pinj_nxt = pinj_r;
    pwd_nxt  = pwd_r;
    ix_nxt   = ix_r;
    rc_nxt   = rc_r;
    r0_nxt   = r0_r;
    r1_nxt   = r1_r;
    ref_nxt  = ref_r;
    auto_nxt = auto_r || (hs2_r && !hs3_r);
    cb_nxt   = cb_r;
    cp_nxt   = cp_r;
    cv_nxt   = 1'b0;
    cl_nxt   = 1'b0;

    if (wp_r && wa_r == `REG_PWD) begin
      pwd_nxt = hwdata;
    end
    case (st_r)
      CTL_IDLE: begin
        ix_nxt = 4'h0;
        if (auto_r) begin
          op_nxt   = `OP_TX_DIS;
          pinj_nxt = 1'b0;
          // a new hold edge in this cycle still wins over the clear
          auto_nxt = hs2_r && !hs3_r;
          st_nxt   = CTL_SEND;
        end else if (wp_r && wa_r == `REG_CMD) begin
          // enabling during hold is refused locally
          ref_nxt = hs2_r && hwdata[7:0] == `OP_TX_EN;
          if (!ref_nxt) begin
            op_nxt   = hwdata[`CMD_OP_LSB +: 8];
            adj_nxt  = hwdata[`CMD_ADJ_LSB +: 8];
            pinj_nxt = hwdata[`CMD_PINJ_BIT];
            st_nxt   = CTL_SEND;
          end
        end
      end
      CTL_SEND: begin
        cb_nxt = nb;
        cp_nxt = ~^nb ^ pinj_r;
        cv_nxt = 1'b1;
        cl_nxt = ix_r == len - 4'h1;
        ix_nxt = ix_r + 4'h1;
        rc_nxt = 2'h0;
        if (ix_r == len - 4'h1) begin
          st_nxt = CTL_WAIT;
        end
      end
      CTL_WAIT: begin
        if (link.r_valid) begin
          rc_nxt = rc_r + 2'h1;
          if (rc_r == 2'h0) begin
            r0_nxt = link.r_byte;
            r1_nxt = 8'h00;
            if (link.r_byte != `RSP_PAIR) begin
              st_nxt = CTL_IDLE;
            end
          end else begin
            r1_nxt = link.r_byte;
            st_nxt = CTL_IDLE;
          end
        end
      end
      default: st_nxt = CTL_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r   <= 1'b0;
      wa_r   <= 8'h00;
      rd_r   <= 32'h0;
      st_r   <= CTL_IDLE;
      op_r   <= 8'h00;
      adj_r  <= 8'h00;
      pinj_r <= 1'b0;
      pwd_r  <= `PWD_RESET;
      ix_r   <= 4'h0;
      rc_r   <= 2'h0;
      r0_r   <= 8'h00;
      r1_r   <= 8'h00;
      ref_r  <= 1'b0;
      auto_r <= 1'b0;
      cb_r   <= 8'h00;
      cp_r   <= 1'b0;
      cv_r   <= 1'b0;
      cl_r   <= 1'b0;
    end else if (ce) begin
      wp_r   <= wp_nxt;
      wa_r   <= wa_nxt;
      rd_r   <= rd_nxt;
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      adj_r  <= adj_nxt;
      pinj_r <= pinj_nxt;
      pwd_r  <= pwd_nxt;
      ix_r   <= ix_nxt;
      rc_r   <= rc_nxt;
      r0_r   <= r0_nxt;
      r1_r   <= r1_nxt;
      ref_r  <= ref_nxt;
      auto_r <= auto_nxt;
      cb_r   <= cb_nxt;
      cp_r   <= cp_nxt;
      cv_r   <= cv_nxt;
      cl_r   <= cl_nxt;
    end
  end

  // zero-wait slave: ready and response are constant after reset
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = rd_r;
  assign link.c_byte  = cb_r;
  assign link.c_par   = cp_r;
  assign link.c_valid = cv_r;
  assign link.c_last  = cl_r;
endmodule

// file: outdoor_tx_control_commands_tb.sv
// testbench: indoor controller and outdoor handler joined by the link
// assumes: two-byte all-zero password, both optional functions built in
`timescale 1ns/1ns
module outdoor_tx_control_commands_tb;
  import tx_cmd_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int LMIN = -64;
  localparam int LMAX = 63;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        [31:0] haddr, hwdata, hrdata;
  logic        [1:0]  htrans;
  logic        [2:0]  hsize;
  logic              hold_state, synth_unlock, supply_fault, alarm;
  logic              lock_active, pa_en, tx_on, mod_en, cw;
  logic              ce, pwd_f, pw_bad;
  logic        [2:0]  fail_cnt;
  logic signed [7:0]  level;
  int                errors, n_tests, n_rsp, n_fail, cyc, lvl, i, k;
  tx_cmd_if link ();
  indoor_tx_ctl #(.PWD_LEN(2)) u_indoor_tx_ctl (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .hold_state(hold_state),
    .link(link));
  outdoor_tx_ctrl #(.PWD_LEN(2)) u_outdoor_tx_ctrl (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .link(link),
    .synth_unlock(synth_unlock), .supply_fault(supply_fault),
    .alarm(alarm), .lock_active(lock_active), .fail_count(fail_cnt),
    .pwd_fail(pwd_f), .power_amplifier_en(pa_en), .tx_power_on(tx_on),
    .mod_enable(mod_en), .cw_carrier(cw), .power_level(level));
  tx_cmd_monitor u_tx_cmd_monitor (
    .hclk(hclk), .hresetn(hresetn), .c_byte(link.c_byte),
    .c_par(link.c_par), .c_valid(link.c_valid), .c_last(link.c_last),
    .r_byte(link.r_byte), .r_valid(link.r_valid));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // reply bytes are counted here so the tasks never miss a pulse
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (link.r_valid === 1'b1) n_rsp <= n_rsp + 1;
    if (pwd_f === 1'b1) n_fail <= n_fail + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic [17:0] exp_rsp(input logic [7:0] op,
                                          input logic lk, pinj);
    if (pinj) return {2'h1, 8'hE6, 8'h00};
    if (!(op inside {[8'hC6:8'hCA], 8'hCE, 8'hCF}))
      return {2'h1, 8'hE7, 8'h00};
    if (lk && op inside {8'hC6, 8'hC7}) return {2'h2, 8'hED, 8'hFF};
    if (lk && op != 8'hCE) return {2'h1, 8'hEA, 8'h00};
    if (pw_bad && op inside {8'hC6, 8'hC8, 8'hCA, 8'hCF})
      return {2'h2, 8'hED, fail_cnt == 3'h4 ? 8'hFE : 8'hF1 + 8'(fail_cnt)};
    return {2'h1, 8'hE4, 8'h00};
  endfunction
  task automatic cmd(input logic [7:0] op, stp, input logic pinj, lk);
    logic [31:0] st;
    logic [17:0] ex;
    int          n0, j;
    n0 = n_rsp;
    ahb(1'b1, 32'h0, {15'h0, pinj, stp, op}, st);
    ex = exp_rsp(op, lk, pinj);
    j = 0;
    do begin
      ahb(1'b0, 32'h8, 32'h0, st);
      j++;
    end while ((st[0] !== 1'b0 || n_rsp == n0) && j < 200);
    chk("reply", 32'({st[5:4], st[15:8],
        st[5:4] == 2'h2 ? st[23:16] : 8'h00}), 32'(ex));
    chk("reply_bytes", 32'(n_rsp - n0), 32'(ex[17:16]));
  endtask
  task automatic wait_off();
    for (int j = 0; j < 20 && tx_on !== 1'b0; j++) @(posedge hclk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] st;
    logic [7:0]  stp;
    hresetn = 1'b0;
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {hold_state, synth_unlock, supply_fault, alarm, lock_active} = '0;
    {pw_bad, fail_cnt} = '0;
    ce = 1'b1;
    void'($urandom(32'hA89A));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pa_reset", 32'(pa_en), 32'h0);
    chk("tx_reset", 32'({tx_on, mod_en, cw, level}), 32'h600);
    cmd(8'hC6, 8'h00, 1'b0, 1'b0);
    chk("pa_on", 32'(pa_en), 32'h1);
    cmd(8'hC7, 8'h00, 1'b0, 1'b0);
    chk("pa_off", 32'(pa_en), 32'h0);
    cmd(8'hC6, 8'h00, 1'b0, 1'b0);
    cmd(8'hCE, 8'h00, 1'b0, 1'b0);
    chk("tx_dis", 32'({tx_on, pa_en}), 32'h0);
    cmd(8'hCF, 8'h00, 1'b0, 1'b0);
    chk("tx_en", 32'({tx_on, pa_en}), 32'h2);
    // a frozen block must not react to a fault until enabled again
    ce <= 1'b0;
    alarm <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("ce_freeze", 32'(tx_on), 32'h1);
    ce <= 1'b1;
    wait_off();
    chk("ce_fault", 32'(tx_on), 32'h0);
    alarm <= 1'b0;
    cmd(8'hCA, 8'h00, 1'b0, 1'b0);
    chk("mod_off", 32'({mod_en, cw}), 32'h1);
    cmd(8'hC9, 8'h00, 1'b0, 1'b0);
    chk("mod_on", 32'({mod_en, cw}), 32'h2);
    // both limits first, then random steps
    lvl = 0;
    for (i = 0; i < 14; i++) begin
      stp = i < 2 ? 8'h7F : (i < 4 ? 8'h80 : 8'($urandom_range(0, 255)));
      cmd(8'hC8, stp, 1'b0, 1'b0);
      lvl = lvl + int'($signed(stp));
      if (lvl > LMAX) lvl = LMAX;
      if (lvl < LMIN) lvl = LMIN;
      chk("level", 32'(level), 32'(lvl));
    end
    cmd(8'hC6, 8'h00, 1'b0, 1'b0);
    cmd(8'hC7, 8'h00, 1'b1, 1'b0);
    chk("pa_parity", 32'(pa_en), 32'h1);
    cmd(8'hC0, 8'h00, 1'b0, 1'b0);
    for (k = 0; k < 3; k++) begin
      cmd(8'hCF, 8'h00, 1'b0, 1'b0);
      {synth_unlock, supply_fault, alarm} <= 3'h4 >> k;
      wait_off();
      chk("fault_off", 32'(tx_on), 32'h0);
      {synth_unlock, supply_fault, alarm} <= 3'h0;
    end
    cmd(8'hCF, 8'h00, 1'b0, 1'b0);
    lock_active <= 1'b1;
    wait_off();
    chk("lock_off", 32'(tx_on), 32'h0);
    cmd(8'hC7, 8'h00, 1'b0, 1'b1);
    foreach (st[j]) if (j < 4) cmd(8'hCF - (j == 1) * 7 - (j > 1) * (j + 3),
                                    8'h01, 1'b0, 1'b1);
    chk("lock_keep", 32'({tx_on, mod_en, level}),
        32'({2'b01, 8'(lvl)}));
    cmd(8'hCE, 8'h00, 1'b0, 1'b1);
    lock_active <= 1'b0;
    repeat (3) @(posedge hclk);
    cmd(8'hCF, 8'h00, 1'b0, 1'b0);
    hold_state <= 1'b1;
    wait_off();
    chk("hold_off", 32'(tx_on), 32'h0);
    ahb(1'b1, 32'h0, 32'h0000_00CF, st);
    ahb(1'b0, 32'h8, 32'h0, st);
    chk("hold_refuse", 32'({st[2], tx_on}), 32'h2);
    hold_state <= 1'b0;
    // wrong password: counts 0, 1 and the fifth attempt
    ahb(1'b1, 32'h4, 32'($urandom_range(1, 65535)), st);
    pw_bad = 1'b1;
    for (k = 0; k < 3; k++) begin
      fail_cnt <= 3'(k * k);
      i = n_fail;
      cmd(8'hC6, 8'h00, 1'b0, 1'b0);
      chk("pwd_fail", 32'(n_fail - i), 32'h1);
    end
    chk("pwd_keep", 32'(pa_en), 32'h0);
    cmd(8'hC7, 8'h00, 1'b0, 1'b0);
    conclude();
  end
endmodule

// file: outdoor_tx_ctrl.sv
// outdoor unit transmit-control command handler
// assumes: link bytes from same-clock logic; fault pins asynchronous
//
// Operation
// - amplifier-off disables amplifier, replies accepted
// - reject with unsupported, parity or format code
// - locked unit refuses amplifier-off with pair
// - amplifier off after any reset
// - transmitter-disable powers down, replies accepted
// - entering lockout powers transmitter down itself
// - controller disables on hold, never enables
// - fault or alarm disables transmitter automatically
// - transmitter-enable powers up, output stays off
// - locked unit rejects enable/power/modulation single byte
// - power step is signed byte count
// - step byte follows command and password
// - unsupported optional functions reply unsupported
// - modulation-on re-enables modulator, replies accepted
// - modulation-off disables modulator, replies accepted
// - modulation off sends clean carrier
// - password appended to amplifier-on, enable, power, modulation-off
// - amplifier-on enables amplifier output
// - fifth wrong password gives distinct pair
`timescale 1ns/1ns
module outdoor_tx_ctrl
  import tx_cmd_pkg::*;
#(
  parameter int          PWD_LEN         = 0,
  parameter logic [31:0] PASSWORD        = 32'h0000_0000,
  parameter bit          POWER_SUPPORTED = 1'b1,
  parameter bit          MOD_SUPPORTED   = 1'b1,
  parameter logic signed [7:0] LEVEL_MIN = -8'sh40,
  parameter logic signed [7:0] LEVEL_MAX = 8'sh3F
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // command link
  tx_cmd_if.dev                  link,
  // fault pins and lockout counter
  input  wire logic              synth_unlock,
  input  wire logic              supply_fault,
  input  wire logic              alarm,
  input  wire logic              lock_active,
  input  wire logic [2:0]        fail_count,
  output logic                   pwd_fail,
  // transmitter controls
  output logic                   power_amplifier_en,
  output logic                   tx_power_on,
  output logic                   mod_enable,
  output logic                   cw_carrier,
  output logic signed [7:0]      power_level
);
  localparam int BUF_N = 8;
  localparam int ADJ_IX = 3 + PWD_LEN;

  if (PWD_LEN < 0 || PWD_LEN > 4) begin : g_bad_pwd
    $error("PWD_LEN must be 0 to 4");
  end
  if (LEVEL_MIN > LEVEL_MAX) begin : g_bad_lim
    $error("LEVEL_MIN above LEVEL_MAX");
  end

  // ----------------------------------------
  // fault pin synchronisers
  // ----------------------------------------
  logic [2:0] flt_s1_r;
  logic [2:0] flt_s2_r;
  logic       lock_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_s1_r <= 3'h0;
      flt_s2_r <= 3'h0;
      lock_d_r <= 1'b0;
    end else if (ce) begin
      flt_s1_r <= {alarm, supply_fault, synth_unlock};
      flt_s2_r <= flt_s1_r;
      lock_d_r <= lock_active;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  dev_state_t        st_r, st_nxt;
  logic [7:0]        buf_r [BUF_N];
  logic [7:0]        buf_nxt [BUF_N];
  logic [3:0]        cnt_r, cnt_nxt;
  logic              perr_r, perr_nxt;
  logic [7:0]        rsp0_r, rsp0_nxt;
  logic [7:0]        rsp1_r, rsp1_nxt;
  logic              two_r, two_nxt;
  logic [7:0]        rb_r, rb_nxt;
  logic              rv_r, rv_nxt;
  logic              pa_r, pa_nxt;
  logic              txp_r, txp_nxt;
  logic              mod_r, mod_nxt;
  logic signed [7:0] lvl_r, lvl_nxt;
  logic              pf_r, pf_nxt;
  logic              cw_r, cw_nxt;

  // ----------------------------------------
  // password compare, one lane per byte
  // ----------------------------------------
  logic [3:0] pwd_hit;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_pwd
    if (gi < PWD_LEN) begin : g_on
      assign pwd_hit[gi] = buf_r[3+gi] == PASSWORD[8*gi +: 8];
    end else begin : g_off
      assign pwd_hit[gi] = 1'b1;
    end
  end

  // ----------------------------------------
  // decode and next state
  // ----------------------------------------
  logic [7:0]        op;
  logic              known;
  logic              needs_pwd;
  logic              optional;
  logic              opt_ok;
  logic [3:0]        exp_len;
  logic signed [9:0] sum;
  logic              fault;

  always_comb begin
    op        = buf_r[2];
    known     = op == `OP_PA_ON || op == `OP_PA_OFF
             || op == `OP_PWR_STEP || op == `OP_MOD_ON
             || op == `OP_MOD_OFF || op == `OP_TX_DIS
             || op == `OP_TX_EN;
    needs_pwd = PWD_LEN > 0 && (op == `OP_PA_ON || op == `OP_TX_EN
             || op == `OP_PWR_STEP || op == `OP_MOD_OFF);
    exp_len   = 4'h3 + (needs_pwd ? 4'(PWD_LEN) : 4'h0)
              + ((op == `OP_PWR_STEP) ? 4'h1 : 4'h0);
    optional  = op == `OP_PWR_STEP || op == `OP_MOD_ON
             || op == `OP_MOD_OFF;
    opt_ok    = op == `OP_PWR_STEP ? POWER_SUPPORTED : MOD_SUPPORTED;
    sum       = 10'(lvl_r) + 10'(signed'(buf_r[ADJ_IX]));
    fault     = |flt_s2_r || (lock_active && !lock_d_r);

    st_nxt   = st_r;
    buf_nxt  = buf_r;
    cnt_nxt  = cnt_r;
    perr_nxt = perr_r;
    rsp0_nxt = rsp0_r;
    rsp1_nxt = rsp1_r;
    two_nxt  = two_r;
    rb_nxt   = rb_r;
    rv_nxt   = 1'b0;
    pa_nxt   = pa_r;
    txp_nxt  = txp_r;
    mod_nxt  = mod_r;
    lvl_nxt  = lvl_r;
    pf_nxt   = 1'b0;

    case (st_r)
      DEV_IDLE: begin
        if (link.c_valid) begin
          if (cnt_r < 4'(BUF_N)) begin
            buf_nxt[cnt_r[2:0]] = link.c_byte;
            cnt_nxt = cnt_r + 4'h1;
          end
          if (!(^{link.c_byte, link.c_par})) begin
            perr_nxt = 1'b1;
          end
          if (link.c_last) begin
            st_nxt = DEV_EXEC;
          end
        end
      end
      DEV_EXEC: begin
        two_nxt = 1'b0;
        rsp1_nxt = `RSP_LOCK_TAIL;
        // one verdict per message, highest first
        if (perr_r) begin
          rsp0_nxt = `RSP_PARITY;
        end else if (buf_r[0] != `CMD_HDR0 || buf_r[1] != `CMD_HDR1
                     || !known || cnt_r != exp_len) begin
          rsp0_nxt = `RSP_FORMAT;
        end else if (optional && !opt_ok) begin
          rsp0_nxt = `RSP_UNSUP;
        end else if (lock_active && (op == `OP_PA_OFF
                     || op == `OP_PA_ON)) begin
          rsp0_nxt = `RSP_PAIR;
          two_nxt  = 1'b1;
        end else if (lock_active && op != `OP_TX_DIS) begin
          rsp0_nxt = `RSP_LOCKED;
        end else if (needs_pwd && !(&pwd_hit)) begin
          rsp0_nxt = `RSP_PAIR;
          two_nxt  = 1'b1;
          pf_nxt   = 1'b1;
          if (fail_count == `PWD_FIFTH_CNT) begin
            rsp1_nxt = `RSP_PWD_FIFTH;
          end else begin
            rsp1_nxt = `RSP_PWD_BASE | {5'h0, fail_count + 3'h1};
          end
        end else begin
          rsp0_nxt = `RSP_OK;
          case (op)
            `OP_PA_ON:   pa_nxt  = 1'b1;
            `OP_PA_OFF:  pa_nxt  = 1'b0;
            `OP_TX_DIS: begin
              txp_nxt = 1'b0;
              pa_nxt  = 1'b0;
            end
            `OP_TX_EN:   txp_nxt = 1'b1;
            `OP_MOD_ON:  mod_nxt = 1'b1;
            `OP_MOD_OFF: mod_nxt = 1'b0;
            `OP_PWR_STEP: begin
              // clamp rather than wrap
              if (sum > 10'(LEVEL_MAX)) begin
                lvl_nxt = LEVEL_MAX;
              end else if (sum < 10'(LEVEL_MIN)) begin
                lvl_nxt = LEVEL_MIN;
              end else begin
                lvl_nxt = sum[7:0];
              end
            end
            default: pa_nxt = pa_r;
          endcase
        end
        st_nxt = DEV_RSP0;
      end
      DEV_RSP0: begin
        rb_nxt = rsp0_r;
        rv_nxt = 1'b1;
        st_nxt = two_r ? DEV_RSP1 : DEV_IDLE;
        cnt_nxt  = 4'h0;
        perr_nxt = 1'b0;
      end
      DEV_RSP1: begin
        rb_nxt = rsp1_r;
        rv_nxt = 1'b1;
        st_nxt = DEV_IDLE;
      end
      default: st_nxt = DEV_IDLE;
    endcase

    // faults override any command in flight
    if (fault) begin
      txp_nxt = 1'b0;
      pa_nxt  = 1'b0;
    end
    // registered so the pin is glitch free
    cw_nxt = ~mod_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r   <= DEV_IDLE;
      for (int i = 0; i < BUF_N; i++) begin
        buf_r[i] <= 8'h00;
      end
      cnt_r  <= 4'h0;
      perr_r <= 1'b0;
      rsp0_r <= 8'h00;
      rsp1_r <= 8'h00;
      two_r  <= 1'b0;
      rb_r   <= 8'h00;
      rv_r   <= 1'b0;
      pa_r   <= 1'b0;
      txp_r  <= 1'b1;
      mod_r  <= 1'b1;
      lvl_r  <= `LEVEL_RESET;
      pf_r   <= 1'b0;
      cw_r   <= 1'b0;
    end else if (ce) begin
      st_r   <= st_nxt;
      buf_r  <= buf_nxt;
      cnt_r  <= cnt_nxt;
      perr_r <= perr_nxt;
      rsp0_r <= rsp0_nxt;
      rsp1_r <= rsp1_nxt;
      two_r  <= two_nxt;
      rb_r   <= rb_nxt;
      rv_r   <= rv_nxt;
      pa_r   <= pa_nxt;
      txp_r  <= txp_nxt;
      mod_r  <= mod_nxt;
      lvl_r  <= lvl_nxt;
      pf_r   <= pf_nxt;
      cw_r   <= cw_nxt;
    end
  end

  assign link.r_byte        = rb_r;
  assign link.r_valid       = rv_r;
  assign pwd_fail           = pf_r;
  assign power_amplifier_en = pa_r;
  assign tx_power_on        = txp_r;
  assign mod_enable         = mod_r;
  assign cw_carrier         = cw_r;
  assign power_level        = lvl_r;
endmodule

// file: tx_cmd_cfg.svh
// constants for the outdoor transmit-control command link
// assumes: included by bare name by the package only; both ends import the package
`ifndef TX_CMD_CFG_SVH
`define TX_CMD_CFG_SVH
// ----------------------------------------
// command bytes
// ----------------------------------------
`define CMD_HDR0      8'hE2
`define CMD_HDR1      8'h82
`define OP_PA_ON      8'hC6
`define OP_PA_OFF     8'hC7
`define OP_PWR_STEP   8'hC8
`define OP_MOD_ON     8'hC9
`define OP_MOD_OFF    8'hCA
`define OP_TX_DIS     8'hCE
`define OP_TX_EN      8'hCF
// ----------------------------------------
// reply bytes
// ----------------------------------------
`define RSP_OK        8'hE4
`define RSP_UNSUP     8'hE5
`define RSP_PARITY    8'hE6
`define RSP_FORMAT    8'hE7
`define RSP_LOCKED    8'hEA
`define RSP_PAIR      8'hED
`define RSP_LOCK_TAIL 8'hFF
`define RSP_PWD_FIFTH 8'hFE
`define RSP_PWD_BASE  8'hF0
`define PWD_FIFTH_CNT 3'h4
// ----------------------------------------
// controller register map and resets
// ----------------------------------------
`define REG_CMD       8'h00
`define REG_PWD       8'h04
`define REG_STATUS    8'h08
`define CMD_OP_LSB    0
`define CMD_ADJ_LSB   8
`define CMD_PINJ_BIT  16
`define ST_BUSY_BIT   0
`define ST_HOLD_BIT   1
`define ST_REFUSE_BIT 2
`define ST_CNT_LSB    4
`define ST_RSP0_LSB   8
`define ST_RSP1_LSB   16
`define PWD_RESET     32'h0000_0000
`define LEVEL_RESET   8'h00
`endif

// file: tx_cmd_if.sv
// byte link between indoor controller and outdoor command handler
// assumes: both ends on one clock, one byte per valid cycle
`timescale 1ns/1ns
interface tx_cmd_if;
  logic [7:0] c_byte;
  logic       c_par;
  logic       c_valid;
  logic       c_last;
  logic [7:0] r_byte;
  logic       r_valid;
  modport dev (input c_byte, c_par, c_valid, c_last,
               output r_byte, r_valid);
  modport ctl (output c_byte, c_par, c_valid, c_last,
               input r_byte, r_valid);
endinterface

// file: tx_cmd_monitor.sv
// link checker for the transmit-control byte link
// assumes: placed beside tx_cmd_if, clock enable held high
`timescale 1ns/1ns
module tx_cmd_monitor (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // link signals
  input  wire logic [7:0] c_byte,
  input  wire logic       c_par,
  input  wire logic       c_valid,
  input  wire logic       c_last,
  input  wire logic [7:0] r_byte,
  input  wire logic       r_valid
);
  // ----------------------------------------
  // message framing and reply timing
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_start;
    c_valid && !$past(c_valid);
  endsequence
  sequence s_end;
    c_valid && c_last;
  endsequence
  property p_hdr0;
    s_start |-> c_byte == 8'hE2;
  endproperty
  a_hdr0: assert property (p_hdr0) else $error("bad first byte");
  property p_hdr1;
    s_start |=> c_valid && c_byte == 8'h82;
  endproperty
  a_hdr1: assert property (p_hdr1) else $error("bad second byte");
  property p_answer;
    s_end |-> ##3 r_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("reply late");
  property p_cause;
    $rose(r_valid) |-> $past(c_valid, 3) && $past(c_last, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("reply uncaused");
  // the controller must leave the link quiet while the reply is due
  property p_quiet;
    s_end |=> !c_valid [*3];
  endproperty
  a_quiet: assert property (p_quiet) else $error("byte during reply");
  property p_code;
    $rose(r_valid) |-> r_byte inside {[8'hE4:8'hE7], 8'hEA, 8'hED};
  endproperty
  a_code: assert property (p_code) else $error("bad reply code");
  property p_single;
    r_valid && r_byte != 8'hED |=> !r_valid;
  endproperty
  a_single: assert property (p_single) else $error("extra reply");
  property p_pair;
    r_valid && !$past(r_valid) && r_byte == 8'hED |=>
      r_valid && r_byte inside {[8'hF1:8'hF4], 8'hFE, 8'hFF};
  endproperty
  a_pair: assert property (p_pair) else $error("bad pair tail");
endmodule

// file: tx_cmd_pkg.sv
// types shared by both ends of the transmit-control link
// assumes: tx_cmd_cfg.svh on the include path
package tx_cmd_pkg;
  `include "tx_cmd_cfg.svh"
  typedef enum logic [3:0] {
    DEV_IDLE = 4'b0001,
    DEV_EXEC = 4'b0010,
    DEV_RSP0 = 4'b0100,
    DEV_RSP1 = 4'b1000
  } dev_state_t;
  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_SEND = 3'b010,
    CTL_WAIT = 3'b100
  } ctl_state_t;
endpackage
